/* File: rtl/prefetch_hint_decode.sv */
// Operation
// - effective address is base register plus sign-extended offset
// - offset is 9 bits in newer release, 16 bits before
// - no visible state change except prepare-for-write hint
// - prefetch never raises address or translation exceptions
// - faulting address moves no data; invisible writebacks may occur
// - side-effect bus or cache errors may be reported or dropped
// - uncached address issues no transaction, leaves line state alone
// - transaction uses the effective address access attribute
// - cached location fetches a block; size and level implementation choice
// - coherent attribute issues a coherent transaction
// - prefetch traffic follows sync barrier ordering
// - hint 0 fetches as load, hint 1 as store
// - hints 6 and 7 retained, not evicted by streamed fetches
// - newer hint 2 marks first-level line least recently used
// - newer hint 3 implementation defined; older 2,3,8-23 reserved
// - newer hints 8-15 act like 0-7 on second level
// - newer hints 16-23 act like 0-7 on third level
// - newer hint 24 raises reserved-instruction exception
// - older hint 24 may be implementation defined
// - newer hints 24 to 31 always raise reserved-instruction exception
// - locked cache lines are never altered by a prefetch
// - misaligned effective address raises no exception
`timescale 1ns/1ps
module prefetch_hint_decode
  import prefetch_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // issue from pipeline
  input wire logic issue_valid,
  input wire logic [INSTR_W-1:0] instr,
  input wire logic [ADDR_W-1:0] base_value,
  input wire logic newer_release,
  // translation result for the effective address
  input wire logic xlat_fault,
  input wire logic [2:0] cache_coherency_attr,
  input wire logic line_locked,
  // ordering and side errors
  input wire logic sync_pending,
  input wire logic side_error,
  input wire logic report_side_errors,
  // cache request and status
  output prefetch_req_t req_reg,
  output logic reserved_instr_exception,
  output logic addr_exception,
  output logic side_error_exception,
  output logic is_prefetch_reg,
  output logic stall_reg
);

  decoded_t fields;
  prefetch_req_t req_next;
  logic [ADDR_W-1:0] eff_addr;
  logic fetch;
  logic for_store;
  logic streamed;
  logic retained;
  logic mark_lru;
  logic impl_op;
  logic prep_write;
  logic reserved;
  cache_level_t level;
  logic accepted;
  logic uncached;
  logic may_issue;
  logic rsvd_next;
  logic err_next;
  logic stall_next;

  instr_field_decode u_decode (
    .instr(instr),
    .newer_release(newer_release),
    .fields(fields)
  );

  hint_classify u_hint (
    .hint(fields.hint),
    .newer(fields.newer),
    .fetch(fetch),
    .for_store(for_store),
    .streamed(streamed),
    .retained(retained),
    .mark_lru(mark_lru),
    .impl_op(impl_op),
    .prep_write(prep_write),
    .reserved(reserved),
    .level(level)
  );

  assign eff_addr = base_value + {{(ADDR_W-16){fields.offset[15]}}, fields.offset};

  assign accepted = issue_valid && fields.is_prefetch && !sync_pending;
  assign uncached = (cache_coherency_attr == ATTR_UNCACHED);
  assign may_issue = accepted && !reserved && !xlat_fault && !uncached && !line_locked
                     && (fetch || mark_lru || impl_op || prep_write);
  assign rsvd_next = issue_valid && fields.is_prefetch && reserved;
  assign err_next = side_error && report_side_errors;
  assign stall_next = issue_valid && fields.is_prefetch && sync_pending;

  always_comb begin
    req_next = '0;
    req_next.valid = may_issue;
    req_next.addr = eff_addr;
    req_next.for_store = for_store;
    req_next.retained = retained;
    req_next.streamed = streamed;
    req_next.mark_lru = mark_lru;
    req_next.impl_op = impl_op;
    req_next.prep_write = prep_write;
    req_next.attr = cache_coherency_attr;
    req_next.coherent = cache_coherency_attr >= ATTR_COHERENT_MIN;
    req_next.level = level;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_reg <= '0;
      reserved_instr_exception <= 1'b0;
      addr_exception <= 1'b0;
      side_error_exception <= 1'b0;
      is_prefetch_reg <= 1'b0;
      stall_reg <= 1'b0;
    end else begin
      req_reg <= req_next;
      reserved_instr_exception <= rsvd_next;
      addr_exception <= 1'b0;
      side_error_exception <= err_next;
      is_prefetch_reg <= accepted;
      stall_reg <= stall_next;
    end
  end

  rsvd_trap_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && fields.is_prefetch && newer_release && fields.hint >= HINT_RSVD_BASE
    |=> reserved_instr_exception && !req_reg.valid)
    else $error("reserved hint did not trap");

  no_addr_exc_a: assert property (@(posedge core_clk) disable iff (rst)
    !addr_exception)
    else $error("address exception from prefetch");

  fault_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && xlat_fault |=> !req_reg.valid)
    else $error("request issued on faulting address");

  uncached_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && cache_coherency_attr == ATTR_UNCACHED |=> !req_reg.valid)
    else $error("request issued on uncached address");

  locked_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && line_locked |=> !req_reg.valid)
    else $error("locked line touched");

  addr_calc_a: assert property (@(posedge core_clk) disable iff (rst)
    may_issue |=> req_reg.addr == $past(base_value) + {{(ADDR_W-16){$past(fields.offset[15])}},
    $past(fields.offset)})
    else $error("effective address wrong");

  sync_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    sync_pending |=> !req_reg.valid && !is_prefetch_reg)
    else $error("prefetch passed pending barrier");

  l2_level_a: assert property (@(posedge core_clk) disable iff (rst)
    may_issue && newer_release && fields.hint[4:3] == 2'b01 |=> req_reg.level == lvl_l2)
    else $error("second level hint misrouted");

  l3_level_a: assert property (@(posedge core_clk) disable iff (rst)
    may_issue && newer_release && fields.hint[4:3] == 2'b10 |=> req_reg.level == lvl_l3)
    else $error("third level hint misrouted");

  store_intent_a: assert property (@(posedge core_clk) disable iff (rst)
    may_issue && fields.hint == 5'h01 |=> req_reg.for_store && !req_reg.streamed)
    else $error("store hint lost");

  coherent_a: assert property (@(posedge core_clk) disable iff (rst)
    may_issue |=> req_reg.coherent == ($past(cache_coherency_attr) >= ATTR_COHERENT_MIN))
    else $error("coherent flag mismatch");

  legacy_decode_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && !newer_release && instr[MAJOR_HI:MAJOR_LO] == MAJOR_PREFETCH && !sync_pending
    |=> is_prefetch_reg)
    else $error("legacy prefetch not accepted");

  newer_decode_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && newer_release && instr[MAJOR_HI:MAJOR_LO] == MAJOR_EXT_CLASS && !sync_pending
    && instr[FUNCT_HI:FUNCT_LO] == FUNCT_PREFETCH && !instr[ZERO_BIT] |=> is_prefetch_reg)
    else $error("newer prefetch not accepted");

  zero_bit_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && newer_release && instr[ZERO_BIT]
    |=> !is_prefetch_reg && !req_reg.valid && !reserved_instr_exception)
    else $error("malformed newer form decoded");

  off9_sign_a: assert property (@(posedge core_clk) disable iff (rst)
    may_issue && newer_release |=> req_reg.addr == $past(base_value)
    + {{(ADDR_W-9){$past(instr[OFF9_HI])}}, $past(instr[OFF9_HI:OFF9_LO])})
    else $error("nine bit offset misapplied");

  off16_sign_a: assert property (@(posedge core_clk) disable iff (rst)
    may_issue && !newer_release |=> req_reg.addr == $past(base_value)
    + {{(ADDR_W-16){$past(instr[15])}}, $past(instr[15:0])})
    else $error("sixteen bit offset misapplied");

  prep_only_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && (newer_release || instr[HINT_HI:HINT_LO] != HINT_PREP_WRITE) |=> !req_reg.prep_write)
    else $error("prepare for write from wrong hint");

  err_report_a: assert property (@(posedge core_clk) disable iff (rst)
    side_error && report_side_errors |=> side_error_exception)
    else $error("side error not reported");

  err_drop_a: assert property (@(posedge core_clk) disable iff (rst)
    !report_side_errors |=> !side_error_exception)
    else $error("side error reported while disabled");

  attr_pass_a: assert property (@(posedge core_clk) disable iff (rst)
    may_issue |=> req_reg.attr == $past(cache_coherency_attr))
    else $error("access attribute not carried");

  l1_level_a: assert property (@(posedge core_clk) disable iff (rst)
    may_issue && (!newer_release || fields.hint < HINT_L2_BASE) |=> req_reg.level == lvl_l1)
    else $error("first level hint misrouted");

  streamed_place_a: assert property (@(posedge core_clk) disable iff (rst)
    may_issue && fields.hint[2:1] == 2'b10 |=> req_reg.streamed && !req_reg.retained)
    else $error("streamed hint lost");

  retained_place_a: assert property (@(posedge core_clk) disable iff (rst)
    may_issue && fields.hint[2:1] == 2'b11 |=> req_reg.retained && !req_reg.streamed)
    else $error("retained hint lost");

  lru_mark_a: assert property (@(posedge core_clk) disable iff (rst)
    may_issue && newer_release && fields.hint == HINT_LRU |=> req_reg.mark_lru && req_reg.level == lvl_l1)
    else $error("lru hint lost");

  old_rsvd_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && fields.is_prefetch && !newer_release && (fields.hint == HINT_LRU
    || fields.hint == HINT_IMPL || (fields.hint >= HINT_L2_BASE && fields.hint < HINT_RSVD_BASE))
    |=> !req_reg.valid && !reserved_instr_exception)
    else $error("older reserved hint acted");

  hint24_trap_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && fields.is_prefetch && newer_release && fields.hint == HINT_RSVD_BASE
    |=> reserved_instr_exception)
    else $error("hint 24 did not trap");

  old_hint24_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && fields.is_prefetch && !newer_release && fields.hint == HINT_RSVD_BASE
    |=> !reserved_instr_exception && req_reg.impl_op)
    else $error("older hint 24 trapped");

  misalign_ok_a: assert property (@(posedge core_clk) disable iff (rst)
    may_issue && eff_addr[1:0] != 2'h0 |=> req_reg.valid && !addr_exception)
    else $error("misaligned prefetch refused");

  stall_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    issue_valid && fields.is_prefetch && sync_pending |=> stall_reg && !req_reg.valid)
    else $error("barrier stall not flagged");

  load_intent_a: assert property (@(posedge core_clk) disable iff (rst)
    may_issue && fields.hint == 5'h00 |=> !req_reg.for_store && !req_reg.streamed && !req_reg.retained)
    else $error("load hint lost");

  cov_load: cover property (@(posedge core_clk) disable iff (rst)
    may_issue && fields.hint == 5'h00);
  cov_retained: cover property (@(posedge core_clk) disable iff (rst)
    req_reg.valid && req_reg.retained);
  cov_rsvd: cover property (@(posedge core_clk) disable iff (rst) reserved_instr_exception);
  cov_stall: cover property (@(posedge core_clk) disable iff (rst) stall_reg);
  cov_level3: cover property (@(posedge core_clk) disable iff (rst) req_reg.valid && req_reg.level == lvl_l3);

endmodule : prefetch_hint_decode

/* File: rtl/prefetch_pkg.sv */
package prefetch_pkg;

  localparam int ADDR_W = 64;
  localparam int INSTR_W = 32;

  // instruction field positions
  localparam int MAJOR_HI = 31;
  localparam int MAJOR_LO = 26;
  localparam int BASE_HI = 25;
  localparam int BASE_LO = 21;
  localparam int HINT_HI = 20;
  localparam int HINT_LO = 16;
  localparam int FUNCT_HI = 5;
  localparam int FUNCT_LO = 0;
  localparam int OFF9_HI = 15;
  localparam int OFF9_LO = 7;
  localparam int ZERO_BIT = 6;

  localparam logic [5:0] MAJOR_PREFETCH = 6'h33;
  localparam logic [5:0] MAJOR_EXT_CLASS = 6'h1F;
  localparam logic [5:0] FUNCT_PREFETCH = 6'h35;

  // hint codes
  localparam logic [4:0] HINT_LRU = 5'h02;
  localparam logic [4:0] HINT_IMPL = 5'h03;
  localparam logic [4:0] HINT_L2_BASE = 5'h08;
  localparam logic [4:0] HINT_L3_BASE = 5'h10;
  localparam logic [4:0] HINT_RSVD_BASE = 5'h18;
  localparam logic [4:0] HINT_PREP_WRITE = 5'h1E;

  localparam logic [2:0] ATTR_UNCACHED = 3'h2;
  localparam logic [2:0] ATTR_COHERENT_MIN = 3'h4;

  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RESET = '0;

  typedef enum logic [1:0] {
    lvl_l1,
    lvl_l2,
    lvl_l3
  } cache_level_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic for_store;
    logic retained;
    logic streamed;
    logic mark_lru;
    logic impl_op;
    logic prep_write;
    logic coherent;
    logic [2:0] attr;
    cache_level_t level;
  } prefetch_req_t;

  typedef struct packed {
    logic is_prefetch;
    logic newer;
    logic [4:0] hint;
    logic [15:0] offset;
  } decoded_t;

endpackage : prefetch_pkg

/* File: rtl/instr_field_decode.sv */
`timescale 1ns/1ps
module instr_field_decode
  import prefetch_pkg::*;
(
  // instruction word and release select
  input wire logic [INSTR_W-1:0] instr,
  input wire logic newer_release,
  // decoded fields
  output decoded_t fields
);

  wire logic legacy_hit;
  wire logic newer_hit;
  wire logic [15:0] off9_ext;

  assign legacy_hit = !newer_release && (instr[MAJOR_HI:MAJOR_LO] == MAJOR_PREFETCH);
  assign newer_hit = newer_release && (instr[MAJOR_HI:MAJOR_LO] == MAJOR_EXT_CLASS)
                     && (instr[FUNCT_HI:FUNCT_LO] == FUNCT_PREFETCH) && !instr[ZERO_BIT];
  assign off9_ext = {{7{instr[OFF9_HI]}}, instr[OFF9_HI:OFF9_LO]};

  assign fields.is_prefetch = legacy_hit || newer_hit;
  assign fields.newer = newer_release;
  assign fields.hint = instr[HINT_HI:HINT_LO];
  assign fields.offset = newer_release ? off9_ext : instr[15:0];

endmodule : instr_field_decode

/* File: rtl/hint_classify.sv */
`timescale 1ns/1ps
module hint_classify
  import prefetch_pkg::*;
(
  // hint and release
  input wire logic [4:0] hint,
  input wire logic newer,
  // classification
  output logic fetch,
  output logic for_store,
  output logic streamed,
  output logic retained,
  output logic mark_lru,
  output logic impl_op,
  output logic prep_write,
  output logic reserved,
  output cache_level_t level
);

  wire logic [2:0] low3;
  wire logic in_l2;
  wire logic in_l3;
  wire logic low_rsvd;

  assign low3 = hint[2:0];
  assign in_l2 = newer && (hint >= HINT_L2_BASE) && (hint < HINT_L3_BASE);
  assign in_l3 = newer && (hint >= HINT_L3_BASE) && (hint < HINT_RSVD_BASE);
  assign low_rsvd = !newer && (hint == HINT_LRU || hint == HINT_IMPL
                    || (hint >= HINT_L2_BASE && hint < HINT_RSVD_BASE));

  assign fetch = !reserved && !low_rsvd && ((hint < HINT_RSVD_BASE) || prep_write)
                 && (low3 != 3'h2) && (low3 != 3'h3);
  assign for_store = low3[0];
  assign streamed = low3[2] && !low3[1];
  assign retained = low3[2] && low3[1];
  assign mark_lru = newer && (low3 == 3'h2) && (hint < HINT_RSVD_BASE);
  assign impl_op = (newer && low3 == 3'h3 && hint < HINT_RSVD_BASE)
                   || (!newer && hint >= HINT_RSVD_BASE && hint != HINT_PREP_WRITE);
  assign prep_write = !newer && (hint == HINT_PREP_WRITE);
  assign reserved = newer && (hint >= HINT_RSVD_BASE);
  assign level = in_l3 ? lvl_l3 : (in_l2 ? lvl_l2 : lvl_l1);

endmodule : hint_classify

/* File: tb/cache_model.sv */
`timescale 1ns/1ps
module cache_model
  import prefetch_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // request from the decoder
  input wire prefetch_req_t req,
  input wire logic inject,
  // error seen while filling
  output logic side_error
);
  // fill error pulse
  // an error only ever follows a real fill, never an idle cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      side_error <= 1'b0;
    end else begin
      side_error <= req.valid && inject;
    end
  end
endmodule : cache_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb
  import prefetch_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic iv = 1'b0, newer = 1'b0, fault = 1'b0, locked = 1'b0, sync = 1'b0, rep = 1'b0, inj = 1'b0;
  logic [INSTR_W-1:0] instr = '0;
  logic [ADDR_W-1:0] base = '0;
  logic [2:0] attr = 3'h0;
  logic side_error, rsv_x, addr_x, side_x, is_pf, stall, exp_se;
  prefetch_req_t req;
  int fails = 0;
  int cmp_count = 0;
  logic [31:0] rng = 32'hA0BA;
  logic e_valid = 1'b0, e_chk = 1'b0, e_rsvd = 1'b0, e_pf = 1'b0, e_stall = 1'b0;
  logic [ADDR_W-1:0] e_addr;
  logic [4:0] e_h;
  logic [2:0] e_attr;
  logic e_lru = 1'b0, e_imp = 1'b0, e_prep = 1'b0;
  logic [1:0] e_lvl;
  logic [2:0] e_place;

  always #2.5 core_clk = ~core_clk;

  prefetch_hint_decode i_prefetch_hint_decode (.core_clk(core_clk), .rst(rst), .issue_valid(iv), .instr(instr),
    .base_value(base), .newer_release(newer), .xlat_fault(fault), .cache_coherency_attr(attr),
    .line_locked(locked), .sync_pending(sync), .side_error(side_error), .report_side_errors(rep),
    .req_reg(req), .reserved_instr_exception(rsv_x), .addr_exception(addr_x),
    .side_error_exception(side_x), .is_prefetch_reg(is_pf), .stall_reg(stall));
  cache_model i_cache_model (.core_clk(core_clk), .rst(rst), .req(req), .inject(inj), .side_error(side_error));

  always @(posedge core_clk) exp_se <= side_error && rep;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [63:0] exp_addr(input logic nw, input logic [31:0] ins, input logic [63:0] b);
    return b + (nw ? {{55{ins[15]}}, ins[15:7]} : {{48{ins[15]}}, ins[15:0]});
  endfunction : exp_addr

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : cmp

  task automatic wrap_up();
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // checks the previous issue, then presents the next; cond = {inj, rep, sync, locked, fault, attr}
  task automatic step(input logic v, input logic nw, input logic [31:0] ins, input logic [63:0] b,
      input logic [7:0] cond);
    logic pf, fetch, blk;
    @(posedge core_clk);
    #1;
    cmp(addr_x, 0);
    cmp(side_x, exp_se);
    if (e_chk) cmp(req.valid, e_valid);
    if (e_chk) cmp(rsv_x, e_rsvd);
    if (e_valid) begin
      cmp(req.addr, e_addr);
      cmp({req.for_store, req.streamed, req.retained}, e_place);
      cmp(req.level, e_lvl);
      cmp({req.mark_lru, req.impl_op, req.prep_write}, {e_lru, e_imp, e_prep});
      cmp({req.coherent, req.attr}, {e_attr >= 3'h4, e_attr});
      cmp(is_pf, 1);
    end
    if (!e_pf) cmp({is_pf, req.valid}, 0);
    if (!e_rsvd) cmp(stall, e_stall);
    iv = v;
    newer = nw;
    instr = ins;
    base = b;
    {inj, rep, sync, locked, fault, attr} = cond;
    pf = nw ? (ins[31:26] == MAJOR_EXT_CLASS && ins[5:0] == FUNCT_PREFETCH && !ins[6]) : ins[31:26] == MAJOR_PREFETCH;
    e_h = ins[20:16];
    e_addr = exp_addr(nw, ins, b);
    e_attr = cond[2:0];
    e_pf = v && pf;
    e_rsvd = e_pf && nw && e_h >= 5'h18;
    e_lru = nw && e_h < 5'h18 && e_h[2:0] == 3'h2;
    e_imp = nw ? (e_h < 5'h18 && e_h[2:0] == 3'h3) : (e_h >= 5'h18 && e_h != 5'h1E);
    e_prep = !nw && e_h == 5'h1E;
    e_lvl = nw ? e_h[4:3] : 2'h0;
    e_place = {e_h[0], e_h[2:1] == 2'h2, e_h[2:1] == 2'h3};
    // older reserved codes 2, 3 and 8 to 23 are left unchecked: their action is free
    fetch = ((nw ? e_h < 5'h18 : e_h < 5'h08) && e_h[2:1] != 2'h1) || e_prep;
    blk = cond[3] | cond[4] | (cond[2:0] == 3'h2);
    e_valid = e_pf && !cond[5] && (fetch || e_lru || e_imp) && !blk;
    e_stall = e_pf && cond[5];
    e_chk = !e_pf || fetch || e_lru || e_imp || e_rsvd;
  endtask : step

  initial begin
    logic [31:0] w;
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    step(1, 0, 32'hCC000004, 64'h100, 8'h00);
    step(1, 0, 32'hCC008000, 64'h1_0000_0001, 8'h04);
    step(1, 1, {MAJOR_EXT_CLASS, 5'h3, 5'h07, 9'h100, 1'b0, FUNCT_PREFETCH}, 64'h3, 8'h05);
    step(1, 1, {MAJOR_EXT_CLASS, 5'h3, 5'h0D, 9'h0FF, 1'b0, FUNCT_PREFETCH}, 64'h0, 8'h06);
    step(1, 1, {MAJOR_EXT_CLASS, 5'h3, 5'h00, 9'h001, 1'b1, FUNCT_PREFETCH}, 64'h0, 8'h00);
    // barrier holds the same prefetch twice, then it goes through
    step(1, 0, 32'hCC010010, 64'h40, 8'h20);
    step(1, 0, 32'hCC010010, 64'h40, 8'h20);
    step(1, 0, 32'hCC010010, 64'h40, 8'h00);
    step(1, 0, 32'hCC000000, 64'h80, 8'h08);
    step(1, 0, 32'hCC000000, 64'h80, 8'h02);
    step(1, 0, 32'hCC000000, 64'h80, 8'h10);
    step(1, 0, 32'hCC000000, 64'h0, 8'hC0);
    step(1, 0, 32'hCC000000, 64'h0, 8'h80);
    step(0, 0, 32'h0, 64'h0, 8'h40);
    step(0, 0, 32'h0, 64'h0, 8'h40);
    for (int i = 0; i < 64; i++) begin
      step(1, i[5], {i[5] ? MAJOR_EXT_CLASS : MAJOR_PREFETCH, 5'h1, i[4:0],
        i[5] ? {9'h011, 1'b0, FUNCT_PREFETCH} : 16'h0044}, 64'h200, 8'h00);
    end
    for (int n = 0; n < 400; n++) begin
      rng = xs(rng);
      w = xs(rng ^ 32'h5A5A);
      step(rng[0] | rng[1], rng[4] ^ (rng[5] & rng[6]), rng[3] ? {rng[4] ? MAJOR_EXT_CLASS : MAJOR_PREFETCH,
        w[25:7], rng[4] ? {1'b0, FUNCT_PREFETCH} : w[6:0]} : w, {w, rng}, {rng[9], rng[10],
        &rng[13:11], &rng[16:14], &rng[19:17], rng[22:20]});
    end
    // idle step so the last random issue is checked too
    step(0, 0, 32'h0, 64'h0, 8'h00);
    wrap_up();
  end

  initial begin
    #10000;
    fails++;
    wrap_up();
  end
endmodule : tb
